//--- bench/opmode_contact_io_monitor.sv
/* Concurrent checks on the mode and contact block, bound to its top.
   Assumes one clock and a synchronous active-high reset. */
module opmode_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire [3:1] contact_i,
  input wire stopping_alarm_i,
  input wire [1:0] mode_o,
  input wire running_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Recent bus writes and raw input 3 history; the sync path delays edges
  logic [3:0] wrq = 4'h0;
  logic [4:0] c3q = 5'h00;
  always @(posedge clk_i) begin
    wrq <= {wrq[2:0], wb_cyc_i & wb_stb_i & wb_we_i};
    c3q <= {c3q[3:0], contact_i[3]};
  end
  wire c3_edge = c3q[2] != c3q[3];
  wire c3_calm = (c3q == 5'h00) || (c3q == 5'h1f);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  local_by_panel_a: assert property (
    $changed(mode_o) && mode_o == 2'h0 |-> |wrq)
    else $error("local mode entered without a bus write");
  serial_cause_a: assert property (
    $changed(mode_o) && mode_o == 2'h2 |-> |wrq)
    else $error("serial mode entered without a bus write");
  contact_cause_a: assert property (
    $changed(mode_o) && mode_o == 2'h1 |-> (|wrq) || c3_edge)
    else $error("contact mode entered without input 3 edge");
  mode_steady_a: assert property (
    wrq == 4'h0 && c3_calm |-> $stable(mode_o))
    else $error("mode moved with steady requests");
  alarm_stops_a: assert property (stopping_alarm_i |=> !running_o)
    else $error("run kept during stopping alarm");
  reset_local_a: assert property (
    $fell(rst_i) |-> mode_o == 2'h0 && !running_o && !irq_o)
    else $error("reset did not leave local idle state");
  cover property ($rose(irq_o));
  cover property ($changed(mode_o) && mode_o == 2'h2);
  cover property ($changed(mode_o) && mode_o == 2'h1);
endmodule // opmode_checker

bind opmode_contact_io opmode_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .contact_i(contact_i),
  .stopping_alarm_i(stopping_alarm_i), .mode_o(mode_o),
  .running_o(running_o), .irq_o(irq_o));

//--- bench/plant_model.sv
/* Plant controller model driving contacts, alarms and ready level.
   Assumes the bench asks for levels; the model applies them late. */
module plant_model (
  input wire clk_i,
  input wire [5:0] req_i,
  input wire [1:0] lag_i,
  output logic [3:1] contact_o,
  output logic stop_o,
  output logic cont_o,
  output logic rdy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lag line lets the plant answer from one up to four cycles late
  logic [5:0] d [0:3] = '{default: 6'h00};
  always @(posedge clk_i) begin
    d[0] <= req_i;
    d[1] <= d[0];
    d[2] <= d[1];
    d[3] <= d[2];
  end
  // Contacts change only after an edge, never mid-cycle
  assign {rdy_o, cont_o, stop_o, contact_o} = d[lag_i];
endmodule // plant_model

//--- bench/test_opmode_contact_io.sv
/* Self-checking bench for the mode and contact block with a reference
   model. Assumes the Wishbone slave answers and a plant model. */
module test_opmode_contact_io;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rq, r, seed = 32'd53;
  logic [15:0] q1 = 16'h0, q2 = 16'h0, q3 = 16'h0, an1, an2;
  logic [5:0] pin = 6'h00;
  logic [1:0] lag = 2'h0, mode;
  logic [3:1] contact;
  logic [6:1] cout;
  logic [2:0] c;
  logic ack, stop_alm, cont_alm, rdy, run, irq;
  logic [11:0] cfg = 12'h000;
  logic [8:0] osel = 9'h000;
  logic [3:0] asel = 4'h9;
  int m_mode = 0, m_run = 0, errors = 0, check_count = 0, i;

  opmode_contact_io #(.AW(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .contact_i(contact),
    .stopping_alarm_i(stop_alm), .continuing_alarm_i(cont_alm),
    .temp_ready_i(rdy), .ch1_temp_i(q1), .ch2_temp_i(q2), .ch2_cond_i(q3),
    .contact_o(cout), .analog1_o(an1), .analog2_o(an2), .mode_o(mode),
    .running_o(run), .irq_o(irq));
  plant_model plant (.clk_i(clk_i), .req_i(pin), .lag_i(lag),
    .contact_o(contact), .stop_o(stop_alm), .cont_o(cont_alm), .rdy_o(rdy));

  // Clock at 25 MHz
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected content of a selectable output from the model state
  function automatic logic pick(input logic [2:0] k);
    logic ex;
    ex = cfg[11] ? pin[0] ^ cfg[1] : pin[1] ^ cfg[2];
    case (k)
      3'h1: return m_run[0];
      3'h2: return pin[3];
      3'h3: return pin[4];
      3'h4: return ex;
      3'h5: return pin[5];
      3'h6: return pin[3] | pin[4];
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] aval(input logic [1:0] k);
    return k == 2'h0 ? q1 : k == 2'h1 ? q2 : k == 2'h2 ? q3 : 16'h0;
  endfunction

  // Let the sync path and plant lag settle, then compare mode, run, contact and analog outputs
  task automatic chk();
    logic [6:1] e;
    repeat (10) @(posedge clk_i);
    e = {pick(osel[8:6]), pick(osel[5:3]), pick(osel[2:0]), pin[4:3],
         m_run[0]} ^ cfg[9:4];
    `CHK(mode, m_mode[1:0])
    `CHK(run, m_run[0])
    `CHK(cout, e)
    `CHK(an1, aval(asel[1:0]))
    `CHK(an2, aval(asel[3:2]))
  endtask

  // One classic cycle; entered right after an edge, returns on an edge.
  // Only the watchdog ends a wait for ack.
  task automatic wb(input logic [7:0] a, input logic [31:0] d,
                    input logic w);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rq = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic setcfg(input logic [11:0] v);
    cfg = v;
    wb(8'h08, {20'h0, v}, 1'b1);
  endtask

  task automatic tdone(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk();
    wb(8'h10, 32'h0, 1'b0);
    `CHK(rq, 32'h9)
    wb(8'h20, 32'hffffffff, 1'b1);
    wb(8'h20, 32'h0, 1'b0);
    `CHK(rq, 32'h0)
    tdone("reset");
    // Mode requests: steady levels and the wrong paths must not move it
    pin[2] <= 1'b1;
    m_mode = 1;
    chk();
    wb(8'h00, 32'h4, 1'b1);
    m_mode = 0;
    chk();
    wb(8'h04, 32'h1, 1'b1);
    m_mode = 2;
    chk();
    wb(8'h00, 32'h4, 1'b1);
    m_mode = 0;
    wb(8'h04, 32'h1, 1'b1);
    chk();
    wb(8'h04, 32'h0, 1'b1);
    chk();
    wb(8'h18, 32'h0, 1'b0);
    `CHK(rq[0], 1'b1)
    `CHK(irq, 1'b0)
    wb(8'h1c, 32'h1, 1'b1);
    wb(8'h1c, 32'h0, 1'b0);
    `CHK(irq, 1'b1)
    wb(8'h18, 32'h1, 1'b1);
    wb(8'h1c, 32'h0, 1'b0);
    `CHK(irq, 1'b0)
    r = rnd();
    lag <= r[1:0];
    pin[2] <= 1'b0;
    chk();
    pin[2] <= 1'b1;
    m_mode = 1;
    chk();
    tdone("mode");
    // Run from input 1: level, pulse, refused as switch, per mode
    pin[0] <= 1'b1;
    m_run = 1;
    chk();
    pin[0] <= 1'b0;
    m_run = 0;
    chk();
    for (i = 0; i < 3; i++) begin
      if (i == 2) setcfg(12'h801);
      else setcfg(12'h001);
      pin[0] <= 1'b1;
      if (i < 2) m_run = 1 - m_run;
      chk();
      pin[0] <= 1'b0;
      chk();
    end
    wb(8'h00, 32'h4, 1'b1);
    m_mode = 0;
    setcfg(12'h000);
    pin[0] <= 1'b1;
    chk();
    pin[0] <= 1'b0;
    wb(8'h00, 32'h18, 1'b1);
    m_run = 1;
    chk();
    pin[3] <= 1'b1;
    m_run = 0;
    chk();
    pin[3] <= 1'b0;
    setcfg(12'h400);
    wb(8'h04, 32'h1, 1'b1);
    m_mode = 2;
    chk();
    pin[0] <= 1'b1;
    m_run = 1;
    chk();
    pin[0] <= 1'b0;
    m_run = 0;
    chk();
    setcfg(12'h000);
    pin[0] <= 1'b1;
    chk();
    pin[0] <= 1'b0;
    wb(8'h04, 32'h3, 1'b1);
    m_run = 1;
    chk();
    wb(8'h04, 32'h1, 1'b1);
    m_run = 0;
    chk();
    tdone("run");
    // Every content code on outputs 4 to 6 with random polarities
    for (i = 0; i < 8; i++) begin
      c = i[2:0];
      osel = {c + 3'h2, c + 3'h1, c};
      r = rnd();
      pin <= {r[17:15], pin[2], r[13:12]};
      wb(8'h0c, {23'h0, osel}, 1'b1);
      setcfg(r[11:0] & 12'h3f6);
      chk();
    end
    tdone("outputs");
    // Analog source selection, every code including the unused one
    for (i = 0; i < 6; i++) begin
      r = rnd();
      q1 <= r[15:0];
      q2 <= r[31:16];
      q3 <= r[23:8];
      asel = r[27:24];
      wb(8'h10, {28'h0, asel}, 1'b1);
      chk();
    end
    tdone("analog");
    // Input 3 closed at rest: opening it is the request
    pin <= 6'h04;
    setcfg(12'h008);
    chk();
    pin[2] <= 1'b0;
    m_mode = 1;
    chk();
    wb(8'h14, 32'h0, 1'b0);
    `CHK(rq[10:0], 11'h049)
    tdone("polarity");
    end_sim();
  end
endmodule // test_opmode_contact_io

//--- logic/opmode_contact_io.v
/*
 * Operation-mode state machine with contact inputs, contact outputs
 * and analog output selection, reached as a classic Wishbone slave.
 * Assumes contact inputs are free-running levels from the plant, the
 * serial stack and the panel both write through this bus, and the
 * measured quantities arrive already scaled on the system clock.
 */
//
// Summary of operation
// - Mode requests act only on an OFF to ON edge, never on level.
// - Rising contact input 3 enters contact-I/O mode.
// - Rising serial mode request flag enters serial mode.
// - Only the panel command path can select local mode.
// - In serial mode with option set, contact input drives run/stop.
// - Input 1 is run/stop or external switch, level or pulse form.
// - Every contact input and output has a selectable NO/NC polarity.
// - Input 3 serves only the mode request and is always momentary.
// - Output 1 shows run or stop state.
// - Output 2 shows a stopping alarm.
// - Output 3 shows a continuing alarm.
// - Outputs 1 to 3 have fixed content; only polarity configurable.
// - Outputs 4 to 6 each take a configurable content and polarity.
// - Each analog output picks CH1 temp, CH2 temp or CH2 conductivity.
// - Status reads in any mode; contact run/stop only when permitted.
// - Reset leaves the block in local mode.
`include "opmode_defs.vh"

module opmode_contact_io #(
  parameter AW = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:1] contact_i,
  input wire stopping_alarm_i,
  input wire continuing_alarm_i,
  input wire temp_ready_i,
  input wire [AW-1:0] ch1_temp_i,
  input wire [AW-1:0] ch2_temp_i,
  input wire [AW-1:0] ch2_cond_i,
  output reg [6:1] contact_o,
  output reg [AW-1:0] analog1_o,
  output reg [AW-1:0] analog2_o,
  output reg [1:0] mode_o,
  output reg running_o,
  output reg irq_o
);

  // Byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = din[k*8 +: 8];
        end
      end
    end
  endfunction

  // Content decode shared by the configurable outputs
  function content;
    input [2:0] code;
    input run;
    input stop_alm;
    input cont_alm;
    input ext_sw;
    input temp_rdy;
    begin
      case (code)
        `OSEL_OFF: content = 1'b0;
        `OSEL_RUN: content = run;
        `OSEL_STOP_ALM: content = stop_alm;
        `OSEL_CONT_ALM: content = cont_alm;
        `OSEL_EXT_SW: content = ext_sw;
        `OSEL_TEMP_RDY: content = temp_rdy;
        `OSEL_ANY_ALM: content = stop_alm | cont_alm;
        default: content = 1'b1;
      endcase
    end
  endfunction

  // Analog quantity selection shared by both analog outputs
  function [AW-1:0] ana_pick;
    input [1:0] code;
    input [AW-1:0] t1;
    input [AW-1:0] t2;
    input [AW-1:0] c2;
    begin
      case (code)
        `ASEL_CH1_TEMP: ana_pick = t1;
        `ASEL_CH2_TEMP: ana_pick = t2;
        `ASEL_CH2_COND: ana_pick = c2;
        default: ana_pick = {AW{1'b0}};
      endcase
    end
  endfunction

  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg run_r;
  reg run_nxt;
  reg [`CFG_WIDTH-1:0] cfg_r;
  reg [8:0] out_sel_r;
  reg [3:0] ana_sel_r;
  reg link_req_r;
  reg [`IRQ_WIDTH-1:0] irq_stat_r;
  reg [`IRQ_WIDTH-1:0] irq_mask_r;
  reg [`IRQ_WIDTH-1:0] irq_set;
  reg [`IRQ_WIDTH-1:0] irq_stat_nxt;
  reg [3:1] sync1_r;
  reg [3:1] sync2_r;
  reg [3:1] prev_r;
  reg stop_alm_prev_r;
  reg ext_sw_prev_r;
  reg [31:0] rd_data;
  wire [3:1] contact_act;
  wire [3:1] contact_rise;
  wire [31:0] cfg_word, out_sel_word, ana_sel_word, mask_word;
  wire [`IRQ_WIDTH-1:0] mask_nxt;
  wire wb_req;
  wire wb_wr;
  wire [31:0] panel_word;
  wire [31:0] link_word;
  wire panel_mode_set;
  wire [1:0] panel_mode;
  wire panel_run_set;
  wire link_wr;
  wire link_req_new;
  wire link_req_rise;
  wire contact_mode_rise;
  wire contact_has_run;
  wire in1_is_run;
  wire ext_sw;
  wire [6:1] out_level;

  // A request is taken once; the ack cycle ends it
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // Two-stage synchroniser on the raw contacts
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= contact_i;
      sync2_r <= sync1_r;
    end
  end

  // NC inputs read inverted; the edge compare runs after polarity
  assign contact_act = sync2_r ^ cfg_r[`CFG_IN_NC_LO +: 3];

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 3'h0;
    end else begin
      prev_r <= contact_act;
    end
  end

  assign contact_rise = contact_act & ~prev_r;

  // Input 3 is always read as a pulse: only its edge matters
  assign contact_mode_rise = contact_rise[3];

  // Input 1 doubles as an external switch when so configured
  assign in1_is_run = ~cfg_r[`CFG_IN1_EXTSW];
  assign ext_sw = cfg_r[`CFG_IN1_EXTSW] ? contact_act[1] :
                  contact_act[2];

  // Panel command word, decoded on its write strobe
  assign panel_word = merge(32'h0, wb_dat_i, wb_sel_i);
  assign panel_mode_set = wb_wr & (wb_adr_i == `OFS_PANEL_CMD) &
                          panel_word[`PCMD_SET_MODE] &
                          (panel_word[1:0] != 2'h3);
  assign panel_mode = panel_word[`PCMD_MODE_LO +: 2];
  assign panel_run_set = wb_wr & (wb_adr_i == `OFS_PANEL_CMD) &
                         panel_word[`PCMD_SET_RUN];

  // Serial request flag is a level; its edge is the event
  assign link_wr = wb_wr & (wb_adr_i == `OFS_LINK_REQ);
  assign link_word = merge({30'h0, running_o, link_req_r},
                           wb_dat_i, wb_sel_i);
  assign link_req_new = link_wr ? link_word[`LREQ_MODE_REQ] : link_req_r;
  assign link_req_rise = link_req_new & ~link_req_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      link_req_r <= 1'b0;
    end else begin
      link_req_r <= link_req_new;
    end
  end

  // Contact run/stop is honoured in contact mode, or in serial mode
  // when the option was set; local mode never listens to it
  assign contact_has_run = in1_is_run &
                           ((mode_r == `MODE_CONTACT) |
                            ((mode_r == `MODE_SERIAL) &
                             cfg_r[`CFG_LINK_RUN]));

  // Mode transitions; the panel wins over a same-cycle request since
  // it is the operator's explicit choice
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      `MODE_LOCAL, `MODE_CONTACT, `MODE_SERIAL: begin
        if (panel_mode_set) begin
          mode_nxt = panel_mode;
        end else if (contact_mode_rise) begin
          mode_nxt = `MODE_CONTACT;
        end else if (link_req_rise) begin
          mode_nxt = `MODE_SERIAL;
        end
      end
      default: mode_nxt = `MODE_LOCAL;
    endcase
  end

  // Run state from whichever source the mode grants
  always @* begin
    run_nxt = run_r;
    if (contact_has_run) begin
      if (cfg_r[`CFG_IN1_PULSE]) begin
        if (contact_rise[1]) begin
          run_nxt = ~run_r;
        end
      end else begin
        run_nxt = contact_act[1];
      end
    end else if (mode_r == `MODE_LOCAL) begin
      if (panel_run_set) begin
        run_nxt = panel_word[`PCMD_RUN];
      end
    end else if (mode_r == `MODE_SERIAL) begin
      if (link_wr) begin
        run_nxt = link_word[`LREQ_RUN];
      end
    end
    // A stopping alarm halts the unit whatever the source
    if (stopping_alarm_i) begin
      run_nxt = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= `MODE_LOCAL;
      run_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      run_r <= run_nxt;
    end
  end

  // Byte-merged write words; each register keeps only its own width
  assign cfg_word = merge({20'h0, cfg_r}, wb_dat_i, wb_sel_i);
  assign out_sel_word = merge({23'h0, out_sel_r}, wb_dat_i, wb_sel_i);
  assign ana_sel_word = merge({28'h0, ana_sel_r}, wb_dat_i, wb_sel_i);
  assign mask_word = merge({28'h0, irq_mask_r}, wb_dat_i, wb_sel_i);
  assign mask_nxt = (wb_wr & (wb_adr_i == `OFS_IRQ_MASK)) ?
                    mask_word[`IRQ_WIDTH-1:0] : irq_mask_r;

  // Configuration registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `CFG_RESET;
      out_sel_r <= `OUT_SEL_RESET;
      ana_sel_r <= `ANA_SEL_RESET;
      irq_mask_r <= 4'h0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `OFS_CFG: begin
          cfg_r <= cfg_word[`CFG_WIDTH-1:0];
        end
        `OFS_OUT_SEL: begin
          out_sel_r <= out_sel_word[8:0];
        end
        `OFS_ANA_SEL: begin
          ana_sel_r <= ana_sel_word[3:0];
        end
        `OFS_IRQ_MASK: begin
          irq_mask_r <= mask_word[`IRQ_WIDTH-1:0];
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle survives the clear
  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_MODE_CHG] = (mode_nxt != mode_r);
    irq_set[`IRQ_RUN_CHG] = (run_nxt != run_r);
    irq_set[`IRQ_STOP_ALM] = stopping_alarm_i & ~stop_alm_prev_r;
    irq_set[`IRQ_EXT_SW] = ext_sw ^ ext_sw_prev_r;
    irq_stat_nxt = irq_stat_r | irq_set;
    if (wb_wr & (wb_adr_i == `OFS_IRQ_STAT) & wb_sel_i[0]) begin
      irq_stat_nxt = (irq_stat_r & ~wb_dat_i[3:0]) | irq_set;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 4'h0;
      stop_alm_prev_r <= 1'b0;
      ext_sw_prev_r <= 1'b0;
    end else begin
      stop_alm_prev_r <= stopping_alarm_i;
      ext_sw_prev_r <= ext_sw;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Read mux; status stays readable whatever the mode
  always @* begin
    case (wb_adr_i)
      `OFS_PANEL_CMD: rd_data = {28'h0, running_o, 1'b0, mode_r};
      `OFS_LINK_REQ: rd_data = {30'h0, running_o, link_req_r};
      `OFS_CFG: rd_data = {20'h0, cfg_r};
      `OFS_OUT_SEL: rd_data = {23'h0, out_sel_r};
      `OFS_ANA_SEL: rd_data = {28'h0, ana_sel_r};
      `OFS_STATUS: begin
        rd_data = {21'h0, temp_ready_i, continuing_alarm_i,
                   stopping_alarm_i, ext_sw, contact_act,
                   contact_has_run, run_r, mode_r};
      end
      `OFS_IRQ_STAT: rd_data = {28'h0, irq_stat_r};
      `OFS_IRQ_MASK: rd_data = {28'h0, irq_mask_r};
      default: rd_data = 32'h0; // Unmapped reads as zero
    endcase
  end

  // Fixed content on outputs 1 to 3
  assign out_level[1] = run_r;
  assign out_level[2] = stopping_alarm_i;
  assign out_level[3] = continuing_alarm_i;

  // Outputs 4 to 6 each pick their own content
  genvar g;
  generate
    for (g = 4; g <= 6; g = g + 1) begin : g_out
      assign out_level[g] = content(out_sel_r[(g-4)*3 +: 3], run_r,
                                    stopping_alarm_i,
                                    continuing_alarm_i, ext_sw,
                                    temp_ready_i);
    end
  endgenerate

  // Output flops; NC outputs are driven inverted
  always @(posedge clk_i) begin
    if (rst_i) begin
      contact_o <= 6'h00;
      analog1_o <= {AW{1'b0}};
      analog2_o <= {AW{1'b0}};
      mode_o <= `MODE_LOCAL;
      running_o <= 1'b0;
      irq_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      contact_o <= out_level ^ cfg_r[`CFG_OUT_NC_LO +: 6];
      analog1_o <= ana_pick(ana_sel_r[1:0], ch1_temp_i, ch2_temp_i,
                            ch2_cond_i);
      analog2_o <= ana_pick(ana_sel_r[3:2], ch1_temp_i, ch2_temp_i,
                            ch2_cond_i);
      mode_o <= mode_nxt;
      running_o <= run_nxt;
      irq_o <= |(irq_stat_nxt & mask_nxt); // Tracks clears and masks
      wb_ack_o <= wb_req; // Ack one cycle after the strobe
      if (wb_req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // opmode_contact_io

//--- logic/opmode_defs.vh
/*
 * Constants for the operation-mode and contact I/O block: register
 * offsets, field positions, reset values, mode and content codes.
 * Assumes inclusion by its bare name from the logic/ folder.
 */
`ifndef OPMODE_DEFS_VH
`define OPMODE_DEFS_VH

// Register byte offsets (32-bit aligned words)
`define OFS_PANEL_CMD   8'h00
`define OFS_LINK_REQ    8'h04
`define OFS_CFG         8'h08
`define OFS_OUT_SEL     8'h0c
`define OFS_ANA_SEL     8'h10
`define OFS_STATUS      8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1c

// Operation modes
`define MODE_LOCAL      2'h0
`define MODE_CONTACT    2'h1
`define MODE_SERIAL     2'h2

// Panel command fields
`define PCMD_MODE_LO    0
`define PCMD_SET_MODE   2
`define PCMD_RUN        3
`define PCMD_SET_RUN    4

// Serial link fields
`define LREQ_MODE_REQ   0
`define LREQ_RUN        1

// Configuration fields
`define CFG_IN1_PULSE   0
`define CFG_IN_NC_LO    1
`define CFG_OUT_NC_LO   4
`define CFG_LINK_RUN    10
`define CFG_IN1_EXTSW   11
`define CFG_WIDTH       12
`define CFG_RESET       12'h000

// Content codes for contact outputs 4 to 6
`define OSEL_OFF        3'h0
`define OSEL_RUN        3'h1
`define OSEL_STOP_ALM   3'h2
`define OSEL_CONT_ALM   3'h3
`define OSEL_EXT_SW     3'h4
`define OSEL_TEMP_RDY   3'h5
`define OSEL_ANY_ALM    3'h6
`define OSEL_ON         3'h7
`define OUT_SEL_RESET   9'h000

// Analog quantity codes
`define ASEL_CH1_TEMP   2'h0
`define ASEL_CH2_TEMP   2'h1
`define ASEL_CH2_COND   2'h2
`define ANA_SEL_RESET   4'h9

// Interrupt status bits
`define IRQ_MODE_CHG    0
`define IRQ_RUN_CHG     1
`define IRQ_STOP_ALM    2
`define IRQ_EXT_SW      3
`define IRQ_WIDTH       4

`endif
